// [bench/acs_analog_model.sv]
// acs_analog_model: analog inputs and comparator of the converter core
module acs_analog_model (
  // converter control
  input wire logic [acs_pkg::RES_W-1:0]   dacCode,
  input wire logic                        sampleHold,
  input wire logic [acs_pkg::CHAN_W-1:0]  inputChannelSelect,
  input wire logic                        referenceConnect,
  // input level of each channel
  input wire logic [acs_pkg::RES_W-1:0]   level [16],
  // comparator
  output logic                            compHigh
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [acs_pkg::RES_W-1:0] held;

  always_latch begin
    if (sampleHold) held <= level[inputChannelSelect];
  end

  // without reference the comparator output is meaningless
  assign compHigh = referenceConnect ? (held >= dacCode) : dacCode[0];
endmodule // acs_analog_model

// [bench/acs_top_props.sv]
// acs_top_props: port assertions of the conversion sequencer
module acs_top_props (
  // clock and reset
  input wire logic                        clk,
  input wire logic                        rst,
  // register port
  input wire logic [acs_pkg::ADDR_W-1:0]  regAddr,
  input wire logic [acs_pkg::DATA_W-1:0]  regWdata,
  input wire logic                        regWrite,
  input wire logic                        regRead,
  input wire logic [acs_pkg::DATA_W-1:0]  regRdata,
  // system and analog side
  input wire logic                        stopMode,
  input wire logic                        convDoneIrq,
  input wire logic [acs_pkg::RES_W-1:0]   dacCode,
  input wire logic                        sampleHold,
  input wire logic [acs_pkg::CHAN_W-1:0]  inputChannelSelect,
  input wire logic                        analogInputEnable,
  input wire logic                        referenceConnect
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic disWrite;
  assign disWrite = regWrite && regAddr == acs_pkg::ADDR_CTRL_ONE
                    && regWdata[6:5] == acs_pkg::MODE_DISABLE;

  a_read_idle: assert property (!$past(regRead) |-> regRdata == 8'h00)
    else $error("read data not zero outside read cycle");
  a_irq_spacing: assert property (convDoneIrq |=> !convDoneIrq [*8])
    else $error("completion pulse too long or too close");
  a_stop_ref: assert property (stopMode |=> !referenceConnect)
    else $error("reference connected in stop");
  a_stop_quiet: assert property (stopMode |=> !convDoneIrq && !sampleHold)
    else $error("activity while stopped");
  a_stop_ctrl: assert property (stopMode |=>
    inputChannelSelect == 4'h0 && !analogInputEnable)
    else $error("control fields not cleared in stop");
  a_disable_idle: assert property (disWrite |=> !convDoneIrq ##1
    (!sampleHold && !convDoneIrq))
    else $error("conversion survives disable write");
  a_sample_len: assert property ($rose(sampleHold) |-> sampleHold [*3])
    else $error("sampling phase too short");
  a_dac_msb: assert property ($fell(sampleHold) && !stopMode
    && !$past(regWrite) |-> dacCode == 10'h200)
    else $error("first trial code wrong");

  c_irq: cover property (convDoneIrq);
  c_stop: cover property ($fell(stopMode));
  c_repeat: cover property (regWrite && regWdata[7]
    && regWdata[6:5] == acs_pkg::MODE_REPEAT);
endmodule // acs_top_props

bind acs_top acs_top_props acs_top_props_i (.clk, .rst, .regAddr, .regWdata,
  .regWrite, .regRead, .regRdata, .stopMode, .convDoneIrq, .dacCode,
  .sampleHold, .inputChannelSelect, .analogInputEnable, .referenceConnect);

// [bench/acs_top_test.sv]
// acs_top_test: self-checking bench of the conversion sequencer
module acs_top_test;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [1:0] ONE = acs_pkg::ADDR_CTRL_ONE;
  localparam logic [1:0] LO  = acs_pkg::ADDR_RES_LOW;
  localparam logic [1:0] HI  = acs_pkg::ADDR_RES_HIGH;
  localparam logic [1:0] SW  = acs_pkg::MODE_SOFTWARE;

  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [1:0] regAddr = 2'h0;
  logic [7:0] regWdata = 8'h00;
  logic       regWrite = 1'b0;
  logic       regRead = 1'b0;
  logic       stopMode = 1'b0;
  logic [7:0] regRdata;
  logic       convDoneIrq;
  logic       compHigh;
  logic [9:0] dacCode;
  logic       sampleHold;
  logic [3:0] chan;
  logic       refOn;
  logic [9:0] level [16];
  logic [7:0] expq [$];
  logic       readSeen = 1'b0;
  logic       seen;
  logic [3:0] ch;
  logic [9:0] prev;
  integer     seed = 51;
  int         fail_count = 0;
  int         total_checks = 0;
  int         cycles = 0;
  int         waited = 0;
  logic [7:0] twoVal = 8'h07;

  always #2 clk = ~clk;

  acs_top acs_top_i (.clk, .rst, .regAddr, .regWdata, .regWrite, .regRead,
    .regRdata, .stopMode, .convDoneIrq, .compHigh, .dacCode, .sampleHold,
    .inputChannelSelect(chan), .analogInputEnable(), .referenceConnect(refOn));
  acs_analog_model acs_analog_model_i (.dacCode, .sampleHold,
    .inputChannelSelect(chan), .referenceConnect(refOn), .level, .compHigh);

  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    expq.push_back(e);
    @(posedge clk);
    regRead <= 1'b0;
  endtask

  task automatic start(input logic [1:0] m, input logic [3:0] c);
    wr(ONE, {1'b0, m, 1'b1, c});
    wr(acs_pkg::ADDR_CTRL_TWO, twoVal);
    wr(ONE, {1'b1, m, 1'b1, c});
  endtask

  task automatic waitIrq(output logic s);
    s = 1'b0;
    waited = 0;
    repeat (400) begin
      @(posedge clk);
      waited++;
      if (convDoneIrq === 1'b1) s = 1'b1;
      if (s) break;
    end
  endtask

  task automatic zeros();
    for (int a = 0; a < 4; a++) rd(2'(a), 8'h00);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk) begin
    readSeen <= regRead;
    if (readSeen) chk(expq.pop_front(), regRdata);
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end
  end

  initial begin
    for (int i = 0; i < 16; i++) level[i] = 10'($random(seed));
    prev = 10'h000;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    zeros();
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      ch = 4'($random(seed));
      start(SW, ch);
      rd(ONE, {1'b0, SW, 1'b1, ch});
      rd(LO, {prev[1:0], 2'h1, 4'h0});
      waitIrq(seen);
      chk(8'h01, {7'h00, seen});
      rd(LO, {level[ch][1:0], 2'h2, 4'h0});
      if (i[0]) begin
        rd(HI, level[ch][9:2]);
        rd(LO, {level[ch][1:0], 6'h00});
      end
      prev = level[ch];
    end
    wr(ONE, {1'b1, acs_pkg::MODE_DISABLE, 1'b1, 4'h5});
    repeat (20) @(posedge clk);
    rd(ONE, 8'h15);
    rd(LO, {prev[1:0], 6'h00});
    $display("test single done");
    start(acs_pkg::MODE_REPEAT, ch);
    repeat (2) begin
      waitIrq(seen);
      chk(8'h01, {7'h00, seen});
    end
    chk(8'(acs_pkg::CONV_156 + 1), 8'(waited));
    rd(LO, {prev[1:0], 2'h3, 4'h0});
    level[ch] = ~prev;
    repeat (50) @(posedge clk);
    wr(ONE, 8'h00);
    wr(ONE, {1'b1, SW, 1'b1, ch});
    waitIrq(seen);
    chk(8'h00, {7'h00, seen});
    rd(LO, {prev[1:0], 2'h2, 4'h0});
    $display("test repeat done");
    start(SW, ch);
    chk(8'h01, {7'h00, refOn});
    repeat (60) @(posedge clk);
    stopMode <= 1'b1;
    repeat (3) @(posedge clk);
    chk(8'h00, {7'h00, refOn});
    stopMode <= 1'b0;
    waitIrq(seen);
    chk(8'h00, {7'h00, seen});
    zeros();
    twoVal = 8'h05;
    start(SW, ch);
    waitIrq(seen);
    chk(8'(acs_pkg::CONV_78 + 3), 8'(waited));
    rd(HI, level[ch][9:2]);
    $display("test stop done");
    repeat (3) @(posedge clk);
    summarize();
  end
endmodule // acs_top_test

// [rtl/acs_pkg.sv]
// acs_pkg: constants and step-length function of the conversion sequencer
package acs_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W   = 2;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned RES_W    = 10;
  localparam int unsigned CHAN_W   = 4;
  localparam int unsigned STEP_W   = 7;
  localparam int unsigned PHASE_W  = 4;
  localparam int unsigned HOLD_W   = 3;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CTRL_ONE  = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_TWO  = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_RES_LOW   = 2'h2;
  localparam logic [ADDR_W-1:0] ADDR_RES_HIGH  = 2'h3;

  // ----------------------------------------------------------------
  // adc_control_one fields
  // ----------------------------------------------------------------
  localparam int unsigned ONE_START_BIT  = 7;
  localparam int unsigned ONE_MODE_LSB   = 5;
  localparam int unsigned ONE_ENABLE_BIT = 4;
  localparam int unsigned ONE_CHAN_LSB   = 0;
  localparam logic [DATA_W-1:0] CTRL_ONE_INIT = 8'h00;

  // ----------------------------------------------------------------
  // adc_control_two fields
  // ----------------------------------------------------------------
  localparam int unsigned TWO_TIME_LSB   = 1;
  localparam int unsigned TWO_REF_BIT    = 0;
  localparam logic [DATA_W-1:0] CTRL_TWO_INIT = 8'h00;
  localparam logic [DATA_W-1:0] CTRL_TWO_MASK = 8'h3F;

  // ----------------------------------------------------------------
  // result register fields
  // ----------------------------------------------------------------
  localparam int unsigned LOW_DATA_LSB   = 6;
  localparam int unsigned LOW_DONE_BIT   = 5;
  localparam int unsigned LOW_BUSY_BIT   = 4;
  localparam int unsigned LOW_RES_BITS   = 2;
  localparam logic [RES_W-1:0] RESULT_INIT = 10'h000;

  // ----------------------------------------------------------------
  // modes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_DISABLE  = 2'h0;
  localparam logic [1:0] MODE_SOFTWARE = 2'h1;
  localparam logic [1:0] MODE_REPEAT   = 2'h3;

  // ----------------------------------------------------------------
  // timing in system clock cycles
  // ----------------------------------------------------------------
  localparam logic [HOLD_W-1:0] HOLDOFF_CYCLES = 3'h4;
  localparam int unsigned CONV_PHASES   = 13;
  localparam int unsigned SAMPLE_PHASES = 3;
  localparam int unsigned CONV_39   = 39;
  localparam int unsigned CONV_78   = 78;
  localparam int unsigned CONV_156  = 156;
  localparam int unsigned CONV_312  = 312;
  localparam int unsigned CONV_624  = 624;
  localparam int unsigned CONV_1248 = 1248;

  // cycles of one phase for a conversion time code
  function automatic logic [STEP_W-1:0] acs_step_len(
    input logic [2:0] code
  );
    int unsigned total;
    unique case (code)
      3'h0:    total = CONV_39;
      3'h2:    total = CONV_78;
      3'h3:    total = CONV_156;
      3'h4:    total = CONV_312;
      3'h5:    total = CONV_624;
      default: total = CONV_1248;
    endcase
    return STEP_W'(total / CONV_PHASES);
  endfunction

endpackage : acs_pkg

// [rtl/acs_sar_core.sv]
// acs_sar_core: successive approximation step engine
module acs_sar_core (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  // control from the sequencer
  input  wire logic                         start,
  input  wire logic                         abort,
  input  wire logic [acs_pkg::STEP_W-1:0]   stepLen,
  // converter core
  input  wire logic                         compHigh,
  output logic      [acs_pkg::RES_W-1:0]    dacCode,
  output logic                              sampleHold,
  // result
  output logic      [acs_pkg::RES_W-1:0]    result,
  output logic                              done
);

  localparam int unsigned PHASE_W = acs_pkg::PHASE_W;
  localparam int unsigned RES_W   = acs_pkg::RES_W;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_TRIAL
  } acs_core_state_t;

  typedef struct packed {
    acs_core_state_t                state;
    logic [acs_pkg::STEP_W-1:0]     stepCnt;
    logic [acs_pkg::PHASE_W-1:0]    phase;
    logic [acs_pkg::RES_W-1:0]      trial;
    logic [acs_pkg::RES_W-1:0]      result;
    logic                           done;
    logic                           sampleHold;
  } acs_core_t;

  acs_core_t s;
  acs_core_t next_s;

  always_comb begin
    next_s      = s;
    next_s.done = 1'b0;
    if (abort) begin
      next_s.state      = ST_IDLE;
      next_s.sampleHold = 1'b0;
      next_s.trial      = '0;
    end else if (start) begin
      next_s.state      = ST_SAMPLE;
      next_s.stepCnt    = stepLen - 1'b1;
      next_s.phase      = '0;
      next_s.trial      = '0;
      next_s.sampleHold = 1'b1;
    end else if (s.state != ST_IDLE) begin
      if (s.stepCnt != '0) begin
        next_s.stepCnt = s.stepCnt - 1'b1;
      end else begin
        next_s.stepCnt = stepLen - 1'b1;
        unique case (s.state)
          ST_SAMPLE: begin
            if (s.phase == PHASE_W'(acs_pkg::SAMPLE_PHASES - 1)) begin
              next_s.state      = ST_TRIAL;
              next_s.sampleHold = 1'b0;
              next_s.phase      = PHASE_W'(acs_pkg::RES_W - 1);
              next_s.trial      = RES_W'(1) << (acs_pkg::RES_W - 1);
            end else begin
              next_s.phase = s.phase + 1'b1;
            end
          end
          ST_TRIAL: begin
            // keep the trial bit only if input is at or above it
            if (!compHigh) begin
              next_s.trial[s.phase] = 1'b0;
            end
            if (s.phase == '0) begin
              next_s.result = next_s.trial;
              next_s.done   = 1'b1;
              next_s.state  = ST_IDLE;
            end else begin
              next_s.phase                  = s.phase - 1'b1;
              next_s.trial[s.phase - 1'b1]  = 1'b1;
            end
          end
          ST_IDLE: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign dacCode    = s.trial;
  assign sampleHold = s.sampleHold;
  assign result     = s.result;
  assign done       = s.done;

endmodule // acs_sar_core

// [rtl/acs_sync3.sv]
// acs_sync3: three-flop synchroniser with agreement filter
module acs_sync3 (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // asynchronous level in, filtered level out
  input  wire logic asyncIn,
  output logic      syncOut
);

  typedef struct packed {
    logic ff1;
    logic ff2;
    logic ff3;
    logic out;
  } acs_sync_t;

  acs_sync_t s;
  acs_sync_t next_s;

  always_comb begin
    next_s     = s;
    next_s.ff1 = asyncIn;
    next_s.ff2 = s.ff1;
    next_s.ff3 = s.ff2;
    // change counts only once second and third agree
    if (s.ff2 == s.ff3) begin
      next_s.out = s.ff3;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign syncOut = s.out;

endmodule // acs_sync3

// [rtl/acs_top.sv]
// acs_top: conversion sequencer with register port and converter control
//
// Chosen here: the address map and the plain strobed port.

// Behaviour
// - software mode plus start bit begins one conversion of selected input
// - conversion end loads result, sets done flag, pulses interrupt together
// - start bit clears itself once the conversion has begun
// - repeat code then start bit converts the selected channel continuously
// - in repeat mode each completion launches the next conversion
// - disable code stops at once and discards the running conversion
// - result high read clears done; new start clears done, keeps old result
// - stop mode aborts, re-initialises both controls, clears results
// - no automatic resume after stop; software restarts itself
// - reference is disconnected while in stop mode
// - each conversion yields a 10-bit unsigned code
// - channel select picks one of sixteen shared analog inputs
// - start refused for four cycles after control one written zero
// - busy set at start, cleared at finish unless relaunched, on disable write and on stop entry
module acs_top (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // register port
  input  wire logic [acs_pkg::ADDR_W-1:0]  regAddr,
  input  wire logic [acs_pkg::DATA_W-1:0]  regWdata,
  input  wire logic                        regWrite,
  input  wire logic                        regRead,
  output logic      [acs_pkg::DATA_W-1:0]  regRdata,
  // system
  input  wire logic                        stopMode,
  output logic                             convDoneIrq,
  // analog side
  input  wire logic                        compHigh,
  output logic      [acs_pkg::RES_W-1:0]   dacCode,
  output logic                             sampleHold,
  output logic      [acs_pkg::CHAN_W-1:0]  inputChannelSelect,
  output logic                             analogInputEnable,
  output logic                             referenceConnect
);

  localparam int unsigned DATA_W = acs_pkg::DATA_W;
  localparam int unsigned RES_W  = acs_pkg::RES_W;
  localparam int unsigned CHAN_W = acs_pkg::CHAN_W;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]                   convModeSelect;
    logic                         convStartBit;
    logic                         analogInputEnable;
    logic [CHAN_W-1:0]            inputChannelSelect;
    logic [2:0]                   convTime;
    logic                         referenceCurrentOn;
    logic [RES_W-1:0]             result;
    logic                         convDoneFlag;
    logic                         convBusyFlag;
    logic [acs_pkg::HOLD_W-1:0]   holdoff;
    logic [DATA_W-1:0]            rdata;
    logic                         irq;
    logic                         refConnect;
    logic [acs_pkg::STEP_W-1:0]   stepLen;
  } acs_state_t;

  acs_state_t s;
  acs_state_t next_s;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic mode_runs(input logic [1:0] mode);
    return (mode == acs_pkg::MODE_SOFTWARE) ||
           (mode == acs_pkg::MODE_REPEAT);
  endfunction

  function automatic logic [DATA_W-1:0] pack_ctrl_one(
    input acs_state_t st
  );
    logic [DATA_W-1:0] v;
    v = '0;
    v[acs_pkg::ONE_START_BIT]  = st.convStartBit;
    v[acs_pkg::ONE_MODE_LSB +: 2] = st.convModeSelect;
    v[acs_pkg::ONE_ENABLE_BIT] = st.analogInputEnable;
    v[acs_pkg::ONE_CHAN_LSB +: CHAN_W] = st.inputChannelSelect;
    return v;
  endfunction

  // top bits of control two read as zero
  function automatic logic [DATA_W-1:0] pack_ctrl_two(
    input acs_state_t st
  );
    logic [DATA_W-1:0] v;
    v = '0;
    v[acs_pkg::TWO_TIME_LSB +: 3] = st.convTime;
    v[acs_pkg::TWO_REF_BIT]       = st.referenceCurrentOn;
    return v;
  endfunction

  // low result bits beside the done and busy flags
  function automatic logic [DATA_W-1:0] pack_result_low(
    input acs_state_t st
  );
    logic [DATA_W-1:0] v;
    v = '0;
    v[acs_pkg::LOW_DATA_LSB +: acs_pkg::LOW_RES_BITS] =
      st.result[acs_pkg::LOW_RES_BITS-1:0];
    v[acs_pkg::LOW_DONE_BIT] = st.convDoneFlag;
    v[acs_pkg::LOW_BUSY_BIT] = st.convBusyFlag;
    return v;
  endfunction

  function automatic logic [DATA_W-1:0] pack_result_high(
    input acs_state_t st
  );
    return st.result[RES_W-1:acs_pkg::LOW_RES_BITS];
  endfunction

  // start bit survives only in a running mode outside the holdoff
  function automatic logic start_accepted(
    input logic [DATA_W-1:0]          data,
    input logic [acs_pkg::HOLD_W-1:0] hold
  );
    return data[acs_pkg::ONE_START_BIT] && (hold == '0)
           && mode_runs(data[acs_pkg::ONE_MODE_LSB +: 2]);
  endfunction

  // state on stop entry; results read zero until the next conversion
  function automatic acs_state_t stop_init(input acs_state_t st);
    acs_state_t v;
    v                    = st;
    v.convModeSelect     = acs_pkg::MODE_DISABLE;
    v.convStartBit       = 1'b0;
    v.analogInputEnable  = 1'b0;
    v.inputChannelSelect = '0;
    v.convTime           = '0;
    v.referenceCurrentOn = 1'b0;
    v.result             = acs_pkg::RESULT_INIT;
    v.convDoneFlag       = 1'b0;
    v.convBusyFlag       = 1'b0;
    v.holdoff            = '0;
    v.irq                = 1'b0;
    return v;
  endfunction

  // ----------------------------------------------------------------
  // comparator crosses from the analog core
  // ----------------------------------------------------------------
  logic compSync;

  acs_sync3 u_comp_sync (
    .clk     (clk),
    .rst     (rst),
    .asyncIn (compHigh),
    .syncOut (compSync)
  );

  // ----------------------------------------------------------------
  // converter step engine
  // ----------------------------------------------------------------
  logic               coreStart;
  logic               coreAbort;
  logic [RES_W-1:0]   coreResult;
  logic               coreDone;

  acs_sar_core u_core (
    .clk        (clk),
    .rst        (rst),
    .start      (coreStart),
    .abort      (coreAbort),
    .stepLen    (s.stepLen),
    .compHigh   (compSync),
    .dacCode    (dacCode),
    .sampleHold (sampleHold),
    .result     (coreResult),
    .done       (coreDone)
  );

  // ----------------------------------------------------------------
  // decode of the current access
  // ----------------------------------------------------------------
  logic             wrOne;
  logic             wrTwo;
  logic             rdHigh;
  logic [1:0]       wrMode;
  logic             disableWrite;
  logic             launch;
  logic             relaunch;

  always_comb begin
    wrOne  = regWrite && (regAddr == acs_pkg::ADDR_CTRL_ONE);
    wrTwo  = regWrite && (regAddr == acs_pkg::ADDR_CTRL_TWO);
    rdHigh = regRead && (regAddr == acs_pkg::ADDR_RES_HIGH);
    wrMode = regWdata[acs_pkg::ONE_MODE_LSB +: 2];
    // writing the disable code drops a running conversion
    disableWrite = wrOne && (wrMode == acs_pkg::MODE_DISABLE);
    // pending start bit launches one cycle after its write
    launch = s.convStartBit && mode_runs(s.convModeSelect)
             && !stopMode && !disableWrite;
    relaunch = coreDone && !s.convStartBit
               && (s.convModeSelect == acs_pkg::MODE_REPEAT)
               && !stopMode && !disableWrite;
    coreStart = launch || relaunch;
    coreAbort = stopMode || disableWrite;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s     = s;
    next_s.irq = 1'b0;
    next_s.rdata = '0;
    next_s.stepLen = acs_pkg::acs_step_len(s.convTime);
    next_s.refConnect = s.referenceCurrentOn && !stopMode;

    if (s.holdoff != '0) begin
      next_s.holdoff = s.holdoff - 1'b1;
    end

    // ----------------------------------------------------------------
    // read data, one cycle after the strobe
    // ----------------------------------------------------------------
    if (regRead) begin
      unique case (regAddr)
        acs_pkg::ADDR_CTRL_ONE: next_s.rdata = pack_ctrl_one(s);
        acs_pkg::ADDR_CTRL_TWO: next_s.rdata = pack_ctrl_two(s);
        acs_pkg::ADDR_RES_LOW:  next_s.rdata = pack_result_low(s);
        acs_pkg::ADDR_RES_HIGH: next_s.rdata = pack_result_high(s);
      endcase
    end

    // ----------------------------------------------------------------
    // flags; result high read clears done, completion below wins
    // ----------------------------------------------------------------
    if (rdHigh) begin
      next_s.convDoneFlag = 1'b0;
    end

    // start bit is consumed whether or not it launched
    if (s.convStartBit) begin
      next_s.convStartBit = 1'b0;
    end
    if (launch) begin
      next_s.convBusyFlag = 1'b1;
      next_s.convDoneFlag = 1'b0;
    end

    if (coreDone && !coreAbort) begin
      next_s.result       = coreResult;
      next_s.convDoneFlag = 1'b1;
      next_s.irq          = 1'b1;
      next_s.convBusyFlag = relaunch;
    end

    // ----------------------------------------------------------------
    // control register writes
    // ----------------------------------------------------------------
    if (wrOne) begin
      next_s.convModeSelect = wrMode;
      next_s.analogInputEnable = regWdata[acs_pkg::ONE_ENABLE_BIT];
      next_s.inputChannelSelect =
        regWdata[acs_pkg::ONE_CHAN_LSB +: CHAN_W];
      next_s.convStartBit = start_accepted(regWdata, s.holdoff);
      if (regWdata == acs_pkg::CTRL_ONE_INIT) begin
        next_s.holdoff = acs_pkg::HOLDOFF_CYCLES;
      end
      if (disableWrite) begin
        next_s.convBusyFlag = 1'b0;
      end
    end
    if (wrTwo) begin
      next_s.convTime = regWdata[acs_pkg::TWO_TIME_LSB +: 3];
      next_s.referenceCurrentOn = regWdata[acs_pkg::TWO_REF_BIT];
    end

    // ----------------------------------------------------------------
    // stop entry re-initialises controls, flags and result; no resume afterwards
    // ----------------------------------------------------------------
    if (stopMode) begin
      next_s = stop_init(next_s);
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign regRdata           = s.rdata;
  assign convDoneIrq        = s.irq;
  assign inputChannelSelect = s.inputChannelSelect;
  assign analogInputEnable  = s.analogInputEnable;
  assign referenceConnect   = s.refConnect;

endmodule // acs_top
